// >>> hw/bbf_host.sv
// host controller that drives the boot block flash pins
`timescale 1ns/1ps

module bbf_host (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// software port
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// flash pins
	output bbf_pkg::bbf_pins_t o_pins,
	input wire logic [15:0] i_dq,
	output logic [15:0] o_dq,
	output logic o_dq_oe
);
	import bbf_pkg::*;

	////////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		ST_IDLE, ST_SETUP, ST_W1, ST_GAP, ST_W2, ST_RD, ST_DONE
	} bbf_state_t;

	bbf_state_t state_reg;
	bbf_op_t op_reg;
	logic [4:0] cnt_reg;
	logic [16:0] addr_reg;
	logic [15:0] data_reg;
	logic [15:0] rd_reg;
	logic [15:0] dq_s1_reg, dq_s2_reg, dq_s3_reg;
	logic top_reg, byte_reg, vpp_reg, unlock_reg, busy_reg, refused_reg;
	logic [31:0] rdata_reg;
	logic [7:0] cmd1;
	logic boot_hit;

	assign boot_hit = is_boot(top_reg, addr_reg);
	assign o_rdata = rdata_reg;

	////////////////////////////////////////////////////////////////////////
	// data pins pass three flops; the host samples late in the read strobe
	always_ff @(posedge i_mclk) begin
		dq_s1_reg <= i_dq;
		dq_s2_reg <= dq_s1_reg;
		dq_s3_reg <= dq_s2_reg;
	end

	// first write of a pair: setup code, or the single command itself
	always_comb begin
		unique case (op_reg)
			BBF_OP_PROG: cmd1 = CMD_PROG_SETUP;
			BBF_OP_ERASE: cmd1 = CMD_ERASE_SETUP;
			BBF_OP_STAT: cmd1 = CMD_READ_STATUS;
			default: cmd1 = data_reg[7:0];
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// software registers
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			rdata_reg <= 32'h00000000;
		end else if (i_rd) begin
			unique case (i_addr)
				REG_CTRL: rdata_reg <= {25'h0000000, unlock_reg, top_reg,
					byte_reg, vpp_reg, 3'h0};
				REG_ADDR: rdata_reg <= {15'h0000, addr_reg};
				REG_DATA: rdata_reg <= {16'h0000, data_reg};
				REG_STATUS: rdata_reg <= {29'h00000000, refused_reg,
					boot_hit, busy_reg};
				REG_RDATA: rdata_reg <= {16'h0000, rd_reg};
				default: rdata_reg <= 32'h00000000;
			endcase
		end else begin
			rdata_reg <= 32'h00000000;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			top_reg <= 1'b0;
			byte_reg <= 1'b0;
			vpp_reg <= 1'b0;
			unlock_reg <= 1'b0;
			addr_reg <= 17'h00000;
			data_reg <= 16'h0000;
		end else if (i_wr && !busy_reg) begin
			if (i_addr == REG_CTRL) begin
				// unlock kept clear of the op field so any op can carry it
				unlock_reg <= i_wdata[6];
				vpp_reg <= i_wdata[3];
				byte_reg <= i_wdata[4];
				top_reg <= i_wdata[5];
			end
			if (i_addr == REG_ADDR)
				addr_reg <= i_wdata[16:0];
			if (i_addr == REG_DATA)
				data_reg <= i_wdata[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// operation sequencer; a start while busy is dropped unflagged; refused marks program or erase without supply
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state_reg <= ST_IDLE;
			op_reg <= BBF_OP_IDLE;
			cnt_reg <= CNT_ZERO;
			busy_reg <= 1'b0;
			refused_reg <= 1'b0;
			rd_reg <= 16'h0000;
		end else begin
			if (i_wr && i_addr == REG_STATUS)
				refused_reg <= 1'b0;
			unique case (state_reg)
				ST_IDLE: begin
					if (i_wr && i_addr == REG_CTRL &&
						i_wdata[2:0] != OP_NONE) begin
						op_reg <= bbf_op_t'(i_wdata[2:0]);
						busy_reg <= 1'b1;
						cnt_reg <= STROBE_CYC;
						if ((i_wdata[2:0] == 3'h3 || i_wdata[2:0] == 3'h4)
							&& !i_wdata[3]) begin
							state_reg <= ST_DONE;
							refused_reg <= 1'b1;
						end else if (i_wdata[2:0] == 3'h1) begin
							state_reg <= ST_RD;
							cnt_reg <= ACCESS_CYC;
						end else begin
							state_reg <= ST_W1;
						end
					end
				end
				ST_W1: begin
					cnt_reg <= cnt_reg - 5'h01;
					if (cnt_reg == CNT_ZERO) begin
						cnt_reg <= STROBE_CYC;
						state_reg <= (op_reg == BBF_OP_CMD) ? ST_DONE : ST_GAP;
					end
				end
				ST_GAP: begin
					cnt_reg <= cnt_reg - 5'h01;
					if (cnt_reg == CNT_ZERO) begin
						cnt_reg <= (op_reg == BBF_OP_STAT) ? ACCESS_CYC
							: STROBE_CYC;
						state_reg <= (op_reg == BBF_OP_STAT) ? ST_RD : ST_W2;
					end
				end
				ST_W2: begin
					cnt_reg <= cnt_reg - 5'h01;
					if (cnt_reg == CNT_ZERO)
						state_reg <= ST_DONE;
				end
				ST_RD: begin
					cnt_reg <= cnt_reg - 5'h01;
					if (cnt_reg == CNT_ZERO) begin
						rd_reg <= dq_s3_reg;
						state_reg <= ST_DONE;
					end
				end
				ST_DONE: begin
					busy_reg <= 1'b0;
					op_reg <= BBF_OP_IDLE;
					state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drive; the rising edge of the write strobe latches addr and data
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
				reset_powerdown_n: 1'b0, boot_unlock_level: 1'b0,
				program_supply_high: 1'b0, byte_n: 1'b1, addr: 17'h00000};
			o_dq <= 16'h0000;
			o_dq_oe <= 1'b0;
		end else begin
			o_pins.reset_powerdown_n <= 1'b1;
			// unlock level stays for the full busy period, boot or not
			o_pins.boot_unlock_level <= unlock_reg;
			o_pins.program_supply_high <= vpp_reg;
			o_pins.byte_n <= !byte_reg;
			o_pins.addr <= addr_reg;
			o_pins.ce_n <= !(state_reg == ST_W1 || state_reg == ST_W2 ||
				state_reg == ST_RD);
			o_pins.oe_n <= !(state_reg == ST_RD);
			// strobe rises a cycle before select and data let go: hold time
			o_pins.we_n <= !((state_reg == ST_W1 || state_reg == ST_W2) &&
				cnt_reg != CNT_ZERO);
			// drive data only while output enable is high
			o_dq_oe <= (state_reg == ST_W1 || state_reg == ST_W2);
			o_dq <= (state_reg == ST_W2) ?
				((op_reg == BBF_OP_ERASE) ? {8'h00, CMD_CONFIRM} : data_reg)
				: {8'h00, cmd1};
		end
	end

	////////////////////////////////////////////////////////////////////////
	bbf_ctl_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		!(o_dq_oe && !o_pins.oe_n))
		else $error("data driven while output enable low");
	rw_excl_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		!(!o_pins.we_n && !o_pins.oe_n))
		else $error("write and output enable together");
	no_vpp_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		(state_reg == ST_W2 && op_reg == BBF_OP_ERASE) |->
		o_pins.program_supply_high)
		else $error("erase confirm without program supply");
	confirm_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		(state_reg == ST_W2 && op_reg == BBF_OP_ERASE) |=> o_dq == 16'h00D0)
		else $error("erase confirm code wrong");
	setup_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		(state_reg == ST_W1 && op_reg == BBF_OP_PROG) |=> o_dq == 16'h0040)
		else $error("program setup code wrong");
	rp_high_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		$past(i_rst) == 1'b0 |-> o_pins.reset_powerdown_n)
		else $error("reset pin low outside reset");
	refuse_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		(state_reg == ST_IDLE && i_wr && i_addr == REG_CTRL &&
		i_wdata[2:0] == 3'h3 && !i_wdata[3]) |=>
		(o_pins.we_n && o_pins.ce_n) [*3])
		else $error("program issued without supply");
	strobe_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		$fell(o_pins.we_n) |-> !o_pins.we_n [*8])
		else $error("write strobe too short");
	strobe_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		$rose(o_pins.we_n) |-> !o_pins.ce_n && o_dq_oe)
		else $error("select or data released with write strobe");
	c_prog_c: cover property (@(posedge i_mclk) state_reg == ST_W2 &&
		op_reg == BBF_OP_PROG);
	c_erase_c: cover property (@(posedge i_mclk) state_reg == ST_W2 &&
		op_reg == BBF_OP_ERASE);
	c_read_c: cover property (@(posedge i_mclk) state_reg == ST_RD);
endmodule

// >>> hw/bbf_pkg.sv
// package for the boot block flash host controller
package bbf_pkg;

	// command codes written to the flash
	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_READ_ID = 8'h90;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] CMD_CONFIRM = 8'hD0;
	localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
	localparam logic [7:0] CMD_PROG_SETUP_ALT = 8'h10;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;

	// block map, word addresses
	localparam logic [16:0] BOT_BOOT_END = 17'h01FFF;
	localparam logic [16:0] BOT_MAIN96_START = 17'h04000;
	localparam logic [16:0] MAIN128_B_START = 17'h10000;
	localparam logic [16:0] TOP_BOOT_START = 17'h1E000;
	localparam logic [16:0] TOP_PARAM_START = 17'h1C000;
	localparam logic [16:0] TOP_MAIN96_END = 17'h1BFFF;
	localparam logic [16:0] ID_ADDR_MFR = 17'h00000;
	localparam logic [16:0] ID_ADDR_DEV = 17'h00001;

	// status bits
	localparam int SR_READY = 7;
	localparam int SR_ERASE_FAIL = 5;
	localparam int SR_PROG_FAIL = 4;

	// software register indices
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h1;
	localparam logic [3:0] REG_DATA = 4'h2;
	localparam logic [3:0] REG_STATUS = 4'h3;
	localparam logic [3:0] REG_RDATA = 4'h4;

	// bus timing in cycles of the 5 ns clock
	localparam int CLK_NS = 5;
	localparam int STROBE_NS = 60;
	localparam int ACCESS_NS = 100;
	localparam logic [4:0] STROBE_CYC = 5'((STROBE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [4:0] ACCESS_CYC = 5'((ACCESS_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [4:0] CNT_ZERO = 5'h00;
	localparam logic [2:0] OP_NONE = 3'h0;

	// operations ordered by software
	typedef enum logic [2:0] {
		BBF_OP_IDLE = 3'h0, BBF_OP_READ = 3'h1, BBF_OP_CMD = 3'h2,
		BBF_OP_PROG = 3'h3, BBF_OP_ERASE = 3'h4, BBF_OP_STAT = 3'h5
	} bbf_op_t;

	// flash pins driven by the host
	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic reset_powerdown_n;
		logic boot_unlock_level;
		logic program_supply_high;
		logic byte_n;
		logic [16:0] addr;
	} bbf_pins_t;

	function automatic logic is_boot(input logic top, input logic [16:0] a);
		is_boot = top ? (a >= TOP_BOOT_START) : (a <= BOT_BOOT_END);
	endfunction

endpackage

// >>> testbench/bbf_flash_model.sv
// behavioural boot block flash seen from its pins
`timescale 1ns/1ps
module bbf_flash_model #(
	parameter logic TOP = 1'b0,
	// address nine held at identifier_high_voltage
	parameter logic ID_HIGH_VOLTAGE = 1'b0,
	parameter logic [15:0] MFR_CODE = 16'h00A5, // arbitrary value
	parameter logic [15:0] DEV_CODE = 16'h5A3C // arbitrary value
) (
	// pins from the host
	input wire bbf_pkg::bbf_pins_t i_pins,
	input wire logic [15:0] i_dq,
	// read side
	output logic [15:0] o_dq,
	output logic o_drive
);
	import bbf_pkg::*;
	logic [15:0] mem [0:131071];
	initial for (int k = 0; k < 131072; k++) mem[k] = 16'hFFFF;
	logic [7:0] sr = 8'h00;
	logic [1:0] mode = 2'h0;
	logic [1:0] pend = 2'h0;
	logic [15:0] rd = 16'h0000;
	time done_at = 0;
	////////////////////////////////////////////////////////////////
	// block index 0 is boot; top map is the bottom map mirrored
	function automatic int blk(input logic [16:0] a);
		logic [16:0] b;
		b = TOP ? ~a : a;
		blk = b < 17'h02000 ? 0 : b < 17'h03000 ? 1 : b < 17'h04000 ? 2 :
			b < 17'h10000 ? 3 : 4;
	endfunction
	////////////////////////////////////////////////////////////////
	// status is sampled at the output enable fall and again on any address or mode change
	always @(negedge i_pins.oe_n or i_pins.addr or mode) begin
		if (mode == 2'h2) rd = {8'h00, $time >= done_at, sr[6:0]};
		else if (mode == 2'h1 || ID_HIGH_VOLTAGE)
			rd = i_pins.addr[0] ? DEV_CODE : MFR_CODE;
		else rd = mem[i_pins.addr];
		if (!i_pins.byte_n) rd[15:8] = 8'h00;
	end
	assign o_drive = !i_pins.ce_n && !i_pins.oe_n &&
		i_pins.reset_powerdown_n;
	// released lines show the inverse so stale data never passes
	assign #40 o_dq = o_drive ? rd : ~rd;
	////////////////////////////////////////////////////////////////
	always @(posedge i_pins.we_n or negedge i_pins.reset_powerdown_n) begin
		if (!i_pins.reset_powerdown_n) begin
			mode = 2'h0;
			pend = 2'h0;
			sr = 8'h00;
			done_at = 0;
		end else if (!i_pins.ce_n) begin
			if ($time < done_at) begin
				if (i_dq[7:0] == CMD_READ_STATUS) mode = 2'h2;
			end else if (pend != 2'h0) begin
				mode = 2'h2;
				if (!i_pins.program_supply_high) sr[3] = 1'b1;
				else if (pend == 2'h2 && i_dq[7:0] != CMD_CONFIRM)
					sr[5:4] = 2'h3;
				else if (blk(i_pins.addr) == 0 && !i_pins.boot_unlock_level)
					if (pend == 2'h1) sr[SR_PROG_FAIL] = 1'b1;
					else sr[SR_ERASE_FAIL] = 1'b1;
				else begin
					done_at = $time + 100;
					if (pend == 2'h1) mem[i_pins.addr] = i_dq;
					else for (int k = 0; k < 131072; k++)
						if (blk(17'(k)) == blk(i_pins.addr))
							mem[k] = 16'hFFFF;
				end
				pend = 2'h0;
			end else begin
				case (i_dq[7:0])
					CMD_READ_ARRAY: mode = 2'h0;
					CMD_READ_ID: mode = 2'h1;
					CMD_READ_STATUS: mode = 2'h2;
					CMD_CLEAR_STATUS: sr[5:3] = 3'h0;
					CMD_PROG_SETUP, CMD_PROG_SETUP_ALT: pend = 2'h1;
					CMD_ERASE_SETUP: pend = 2'h2;
					default: ;
				endcase
			end
		end
	end
endmodule

// >>> testbench/bbf_host_tb.sv
// self-checking bench for the boot block flash host controller
`timescale 1ns/1ps
module bbf_host_tb;
	import bbf_pkg::*;
	localparam logic [15:0] MFR = 16'h00A5;
	localparam logic [15:0] DEV = 16'h5A3C;
	localparam logic [31:0] SUP = 32'h00000008;
	localparam logic [31:0] BYT = 32'h00000010;
	localparam logic [31:0] TP = 32'h00000020;
	localparam logic [31:0] UNL = 32'h00000040;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic [3:0] i_addr = 4'h0;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [31:0] o_rdata, v;
	bbf_pins_t o_pins;
	logic [15:0] o_dq, fl_dq, dq_bus;
	logic o_dq_oe, fl_drive;
	int n_fail = 0;
	int comparisons = 0;
	int cycles = 0;
	always #2.5 i_mclk = ~i_mclk;
	assign dq_bus = o_dq_oe ? o_dq : fl_dq;
	bbf_host dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_pins(o_pins), .i_dq(dq_bus), .o_dq(o_dq), .o_dq_oe(o_dq_oe));
	bbf_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) flash (.i_pins(o_pins),
		.i_dq(dq_bus), .o_dq(fl_dq), .o_drive(fl_drive));
	////////////////////////////////////////////////////////////////
	task automatic results();
		if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge i_mclk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask
	// start one operation and poll busy under a bound
	task automatic op(input logic [31:0] c, input logic [16:0] a,
		input logic [15:0] d);
		int n;
		n = 0;
		wr(REG_ADDR, {15'h0, a});
		wr(REG_DATA, {16'h0, d});
		wr(REG_CTRL, c);
		do begin
			rd(REG_STATUS);
			n++;
		end while (v[0] !== 1'b0 && n < 300);
		if (n >= 300) check(v, 32'h0);
	endtask
	task automatic cmd(input logic [7:0] c);
		op(32'(BBF_OP_CMD) | SUP, 17'h0, {8'h00, c});
	endtask
	task automatic get(input logic [31:0] c, input logic [16:0] a);
		op(32'(BBF_OP_READ) | c, a, 16'h0);
		rd(REG_RDATA);
	endtask
	task automatic stat();
		op(32'(BBF_OP_STAT) | SUP, 17'h0, 16'h0);
		rd(REG_RDATA);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		check({31'h0, o_pins.reset_powerdown_n}, 32'h0);
		check({31'h0, o_dq_oe}, 32'h0);
		i_rst <= 1'b0;
		@(posedge i_mclk);
		#1 check({31'h0, o_pins.reset_powerdown_n}, 32'h1);
	endtask
	task automatic t_ident();
		cmd(CMD_READ_ID);
		get(SUP, ID_ADDR_MFR);
		check(v, {16'h0, MFR});
		get(SUP | BYT, ID_ADDR_DEV);
		check(v, {24'h0, DEV[7:0]});
		get(SUP, ID_ADDR_DEV);
		check(v, {16'h0, DEV});
		cmd(CMD_READ_ARRAY);
		get(SUP, ID_ADDR_MFR);
		check(v, 32'h0000FFFF);
	endtask
	task automatic t_prog();
		op(32'(BBF_OP_PROG) | SUP, 17'h02000, 16'h1234);
		rd(REG_STATUS);
		check({30'h0, v[2:1]}, 32'h0);
		stat();
		check(v, 32'h00000080);
		op(32'(BBF_OP_PROG) | SUP, 17'h03000, 16'hAAAA);
		cmd(CMD_READ_ARRAY);
		get(SUP, 17'h02000);
		check(v, 32'h00001234);
		op(32'(BBF_OP_PROG) | SUP, 17'h01FFF, 16'h0F0F);
		rd(REG_STATUS);
		check({31'h0, v[1]}, 32'h1);
		stat();
		check(v, 32'h00000090);
		cmd(CMD_CLEAR_STATUS);
		stat();
		check(v, 32'h00000080);
		op(32'(BBF_OP_ERASE) | SUP, 17'h02000, 16'h0);
		stat();
		check(v, 32'h00000080);
		cmd(CMD_READ_ARRAY);
		get(SUP, 17'h02000);
		check(v, 32'h0000FFFF);
		get(SUP, 17'h03000);
		check(v, 32'h0000AAAA);
		get(SUP, 17'h01FFF);
		check(v, 32'h0000FFFF);
		op(32'(BBF_OP_PROG) | SUP | UNL, 17'h01FFF, 16'h0F0F);
		stat();
		check(v, 32'h00000080);
		cmd(CMD_READ_ARRAY);
		get(SUP, 17'h01FFF);
		check(v, 32'h00000F0F);
	endtask
	task automatic t_refuse();
		op(32'(BBF_OP_PROG), 17'h04000, 16'h0001);
		rd(REG_STATUS);
		check({31'h0, v[2]}, 32'h1);
		wr(REG_STATUS, 32'h0);
		rd(REG_STATUS);
		check({31'h0, v[2]}, 32'h0);
		get(SUP, 17'h04000);
		check(v, 32'h0000FFFF);
		op(32'(BBF_OP_PROG) | SUP | TP, 17'h1E000, 16'h0001);
		rd(REG_STATUS);
		check({31'h0, v[1]}, 32'h1);
		op(32'(BBF_OP_PROG) | SUP | TP, 17'h1DFFF, 16'h0001);
		rd(REG_STATUS);
		check({31'h0, v[1]}, 32'h0);
		rd(REG_ADDR);
		check(v, 32'h0001DFFF);
		rd(REG_CTRL);
		check(v, 32'h00000028);
		rd(4'hF);
		check(v, 32'h0);
	endtask
	////////////////////////////////////////////////////////////////
	always @(posedge i_mclk) begin
		cycles++;
		if (o_dq_oe === 1'b1 && fl_drive === 1'b1) check(32'h1, 32'h0);
		if (cycles == 30000) begin
			n_fail++;
			results();
		end
	end
	initial begin
		repeat (5) @(posedge i_mclk);
		t_reset();
		t_ident();
		t_prog();
		t_refuse();
		results();
	end
endmodule
